// File: hdl/dap_cnt.sv
// One 12-bit autoreload upcounter with overflow event.
`timescale 1ns/1ps
`include "dap_defines.svh"
module dap_cnt
  import dap_pkg::*;
(
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire logic     i_tick,
  input  wire logic     i_run,
  input  wire logic     i_force,
  input  wire logic     i_clear,
  input  wire dap_cnt_t i_arr,
  output dap_cnt_t      o_cnt,
  output logic          o_ovf
);
  dap_cnt_t cnt_r;
  dap_cnt_t cnt_nxt;

  assign o_cnt = cnt_r;
  // A forced update behaves as an overflow.
  assign o_ovf = !i_clear && (i_force || (i_run && i_tick && cnt_r == `DAP_CNT_MAX));

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_clear)
    begin
      cnt_nxt = '0;
    end
    else if (o_ovf)
    begin
      cnt_nxt = i_arr;
    end
    else if (i_run && i_tick)
    begin
      cnt_nxt = cnt_r + 12'h001;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// File: hdl/dap_defines.svh
// Offsets, field positions, reset values and limits of the dual autoreload PWM unit.
`ifndef DAP_DEFINES_SVH
`define DAP_DEFINES_SVH

`define DAP_AW          8
`define DAP_CW          12
`define DAP_CNT_MAX     12'hfff

`define DAP_OFF_CTRL    8'h00
`define DAP_OFF_ARR1    8'h04
`define DAP_OFF_ARR2    8'h08
`define DAP_OFF_DUTY0   8'h0c
`define DAP_OFF_DUTY1   8'h10
`define DAP_OFF_DUTY2   8'h14
`define DAP_OFF_DUTY3   8'h18
`define DAP_OFF_OCTL    8'h1c
`define DAP_OFF_DTR     8'h20
`define DAP_OFF_BRK     8'h24
`define DAP_OFF_STAT    8'h28

`define DAP_CTRL_SCE    0
`define DAP_CTRL_TE1    1
`define DAP_CTRL_TE2    2
`define DAP_CTRL_FU1    3
`define DAP_CTRL_FU2    4
`define DAP_CTRL_TB     5
`define DAP_CTRL_RST    6'h06

`define DAP_OCTL_POL    4
`define DAP_DTR_DTE     7

`define DAP_BRK_BREAK_FUNCTION_ENABLE    0
`define DAP_BRK_BREAK_SOURCE_SELECT   1
`define DAP_BRK_LVL     2
`define DAP_BRK_BA      3
`define DAP_BRK_PAT     4
`define DAP_BRK_BREAK_COUNTER_ENABLE_ONE   8
`define DAP_BRK_BREAK_COUNTER_ENABLE_TWO   9

`define DAP_RESP_OKAY   2'b00
`define DAP_RESP_SLVERR 2'b10

`endif

// File: hdl/dap_pkg.sv
// Types shared by the dual autoreload PWM unit.
package dap_pkg;
  `include "dap_defines.svh"

  typedef struct packed {
    logic                awvalid;
    logic [`DAP_AW-1:0]  awaddr;
    logic                wvalid;
    logic [31:0]         wdata;
    logic [3:0]          wstrb;
    logic                bready;
    logic                arvalid;
    logic [`DAP_AW-1:0]  araddr;
    logic                rready;
  } dap_axi_req_t;

  typedef struct packed {
    logic                awready;
    logic                wready;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                arready;
    logic                rvalid;
    logic [31:0]         rdata;
    logic [1:0]          rresp;
  } dap_axi_rsp_t;

  typedef logic [`DAP_CW-1:0] dap_cnt_t;
endpackage

// File: hdl/dap_top.sv
// Dual 12-bit autoreload PWM unit with AXI4-Lite registers, dead time and break.
//
// Overview of operation
// - Second counter enable selects single mode or dual mode for outputs two/three.
// - Counters reload from autoreload value on overflow and count up to top.
// - Counters start from zero after reset.
// - Preload compares move to active compares only on overflow with transfer enabled.
// - Transfer enable one gates counter-one outputs, enable two gates counter-two outputs.
// - Outputs go high on overflow and low on compare match.
// - Polarity bits invert outputs, updated at overflow when transfer enable is set.
// - Each output has its own enable bit in the output control register.
// - Dead time between outputs zero and one is count times counter-one tick.
// - Dead-time register value applies only after the next counter-one overflow.
// - Dead time enabled with zero count holds outputs low, except those an active break drives with its pattern.
// - Output zero rises a dead time after overflow, output one after match.
// - Dead time does not work when counting from the millisecond timebase.
// - Level select sets pin active level; pin or software sets break-active.
// - Break enable two covers outputs two/three in dual mode, else enable one.
// - Active break forces the pattern onto enabled outputs after polarity.
// - Active break clears and stops each counter it covers, and clears both autoreloads and all compares.
//
// The implementer's own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "dap_defines.svh"
module dap_top
  import dap_pkg::*;
(
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire dap_axi_req_t i_axi,
  output dap_axi_rsp_t      o_axi,
  input  wire logic         i_ms_tick,
  input  wire logic         i_break_pin,
  output logic [3:0]        o_pwm
);
  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
      begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // Register bus
  // ************************************************************
  logic              aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [`DAP_AW-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0]       w_data_r, w_data_nxt;
  logic [3:0]        w_strb_r, w_strb_nxt;
  logic              bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]        bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  logic              aw_ok, w_ok, wr_en, rd_en, wr_hit, rd_hit;
  logic [`DAP_AW-1:0] wr_addr;
  logic [31:0]       wr_data, rd_val;
  logic [3:0]        wr_strb;

  assign o_axi.awready = !aw_have_r && !bvalid_r;
  assign o_axi.wready  = !w_have_r && !bvalid_r;
  assign o_axi.bvalid  = bvalid_r;
  assign o_axi.bresp   = bresp_r;
  assign o_axi.arready = !rvalid_r;
  assign o_axi.rvalid  = rvalid_r;
  assign o_axi.rdata   = rdata_r;
  assign o_axi.rresp   = rresp_r;

  assign aw_ok   = aw_have_r || (i_axi.awvalid && o_axi.awready);
  assign w_ok    = w_have_r || (i_axi.wvalid && o_axi.wready);
  assign wr_en   = aw_ok && w_ok && !bvalid_r;
  assign wr_addr = aw_have_r ? aw_addr_r : i_axi.awaddr;
  assign wr_data = w_have_r ? w_data_r : i_axi.wdata;
  assign wr_strb = w_have_r ? w_strb_r : i_axi.wstrb;
  assign wr_hit  = wr_addr[1:0] == 2'b00 && wr_addr <= `DAP_OFF_BRK;
  assign rd_en   = i_axi.arvalid && o_axi.arready;
  assign rd_hit  = i_axi.araddr[1:0] == 2'b00 && i_axi.araddr <= `DAP_OFF_STAT;

  always_comb
  begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r && !i_axi.bready;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r && !i_axi.rready;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    if (i_axi.awvalid && o_axi.awready)
    begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = i_axi.awaddr;
    end
    if (i_axi.wvalid && o_axi.wready)
    begin
      w_have_nxt = 1'b1;
      w_data_nxt = i_axi.wdata;
      w_strb_nxt = i_axi.wstrb;
    end
    if (wr_en)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = wr_hit ? `DAP_RESP_OKAY : `DAP_RESP_SLVERR;
    end
    if (rd_en)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = rd_hit ? `DAP_RESP_OKAY : `DAP_RESP_SLVERR;
      rdata_nxt  = rd_hit ? rd_val : 32'h0000_0000;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      aw_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'b00;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'b00;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ************************************************************
  // Timer state
  // ************************************************************
  logic [5:0]  ctrl_r, ctrl_nxt;
  dap_cnt_t    arr1_r, arr1_nxt, arr2_r, arr2_nxt;
  dap_cnt_t    pre_r [4];
  dap_cnt_t    pre_nxt [4];
  dap_cnt_t    act_r [4];
  dap_cnt_t    act_nxt [4];
  logic [7:0]  octl_r, octl_nxt, dtr_r, dtr_nxt, dt_act_r, dt_act_nxt;
  logic [9:0]  brk_r, brk_nxt;
  logic [3:0]  pol_act_r, pol_act_nxt, raw_r, raw_nxt, out_r, out_nxt;
  logic [6:0]  dc0_r, dc0_nxt, dc1_r, dc1_nxt;
  logic [1:0]  sync_r;
  dap_cnt_t    cnt1, cnt2;
  logic        ovf1, ovf2, tick, sce, brk1, brk2, pin_hit, dt_on, dt_hold, fu1, fu2;
  logic [31:0] m;

  assign sce  = ctrl_r[`DAP_CTRL_SCE];
  assign tick = ctrl_r[`DAP_CTRL_TB] ? i_ms_tick : 1'b1;
  assign fu1  = wr_en && wr_hit && wr_addr == `DAP_OFF_CTRL && wr_strb[0]
                && wr_data[`DAP_CTRL_FU1];
  assign fu2  = wr_en && wr_hit && wr_addr == `DAP_OFF_CTRL && wr_strb[0]
                && wr_data[`DAP_CTRL_FU2];
  assign brk1 = brk_r[`DAP_BRK_BA] && brk_r[`DAP_BRK_BREAK_FUNCTION_ENABLE] && brk_r[`DAP_BRK_BREAK_COUNTER_ENABLE_ONE];
  // Single mode lets enable one cover outputs two and three as well.
  assign brk2 = brk_r[`DAP_BRK_BA] && brk_r[`DAP_BRK_BREAK_FUNCTION_ENABLE]
                && (sce ? brk_r[`DAP_BRK_BREAK_COUNTER_ENABLE_TWO] : brk_r[`DAP_BRK_BREAK_COUNTER_ENABLE_ONE]);
  assign pin_hit = brk_r[`DAP_BRK_BREAK_FUNCTION_ENABLE] && brk_r[`DAP_BRK_BREAK_SOURCE_SELECT]
                   && (sync_r[1] == brk_r[`DAP_BRK_LVL]);
  assign dt_on   = dt_act_r[`DAP_DTR_DTE] && !ctrl_r[`DAP_CTRL_TB];
  assign dt_hold = dt_on && dt_act_r[6:0] == 7'h00;

  dap_cnt u_cnt1 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_tick  (tick),
    .i_run   (!brk1),
    .i_force (fu1),
    .i_clear (brk1),
    .i_arr   (arr1_r),
    .o_cnt   (cnt1),
    .o_ovf   (ovf1)
  );

  dap_cnt u_cnt2 (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_tick  (tick),
    .i_run   (sce && !brk2),
    .i_force (fu2 && sce),
    .i_clear (brk2 && sce),
    .i_arr   (arr2_r),
    .o_cnt   (cnt2),
    .o_ovf   (ovf2)
  );

  // Current word of a register, shared by read data and byte-lane merging on writes.
  function automatic logic [31:0] reg_word(input logic [`DAP_AW-1:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `DAP_OFF_CTRL:  v = {26'h0, ctrl_r};
      `DAP_OFF_ARR1:  v = {20'h0, arr1_r};
      `DAP_OFF_ARR2:  v = {20'h0, arr2_r};
      `DAP_OFF_DUTY0: v = {20'h0, pre_r[0]};
      `DAP_OFF_DUTY1: v = {20'h0, pre_r[1]};
      `DAP_OFF_DUTY2: v = {20'h0, pre_r[2]};
      `DAP_OFF_DUTY3: v = {20'h0, pre_r[3]};
      `DAP_OFF_OCTL:  v = {24'h0, octl_r};
      `DAP_OFF_DTR:   v = {24'h0, dtr_r};
      `DAP_OFF_BRK:   v = {22'h0, brk_r};
      `DAP_OFF_STAT:  v = {4'h0, cnt2, 4'h0, cnt1};
      default:        v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign rd_val = reg_word(i_axi.araddr);

  always_comb
  begin
    logic       ov, te, pre_out;
    ov = 1'b0;
    te = 1'b0;
    pre_out = 1'b0;
    m = merge(reg_word(wr_addr), wr_data, wr_strb);
    ctrl_nxt = ctrl_r;
    arr1_nxt = arr1_r;
    arr2_nxt = arr2_r;
    octl_nxt = octl_r;
    dtr_nxt  = dtr_r;
    brk_nxt  = brk_r;
    pre_nxt  = pre_r;
    act_nxt  = act_r;
    pol_act_nxt = pol_act_r;
    dt_act_nxt  = dt_act_r;
    raw_nxt  = raw_r;
    if (wr_en && wr_hit)
    begin
      case (wr_addr)
        `DAP_OFF_CTRL:  ctrl_nxt = m[5:0] & 6'h27;
        `DAP_OFF_ARR1:  arr1_nxt = m[11:0];
        `DAP_OFF_ARR2:  arr2_nxt = m[11:0];
        `DAP_OFF_DUTY0: pre_nxt[0] = m[11:0];
        `DAP_OFF_DUTY1: pre_nxt[1] = m[11:0];
        `DAP_OFF_DUTY2: pre_nxt[2] = m[11:0];
        `DAP_OFF_DUTY3: pre_nxt[3] = m[11:0];
        `DAP_OFF_OCTL:  octl_nxt = m[7:0];
        `DAP_OFF_DTR:   dtr_nxt  = m[7:0];
        `DAP_OFF_BRK:   brk_nxt  = m[9:0];
        default:        ctrl_nxt = ctrl_r;
      endcase
    end
    // The pin sets break-active even in the cycle software clears it.
    if (pin_hit)
    begin
      brk_nxt[`DAP_BRK_BA] = 1'b1;
    end
    if (ovf1)
    begin
      dt_act_nxt = dtr_r;
    end
    for (int i = 0; i < 4; i++)
    begin
      ov = (sce && i >= 2) ? ovf2 : ovf1;
      te = (sce && i >= 2) ? ctrl_r[`DAP_CTRL_TE2] : ctrl_r[`DAP_CTRL_TE1];
      if (ov && te)
      begin
        act_nxt[i]     = pre_r[i];
        pol_act_nxt[i] = octl_r[`DAP_OCTL_POL + i];
      end
      // Match one tick early, so the fall lines up with the count as the rise does with reload.
      if (ov)
      begin
        raw_nxt[i] = 1'b1;
      end
      else if (tick && ((sce && i >= 2) ? cnt2 : cnt1) + 12'h001 == act_r[i])
      begin
        raw_nxt[i] = 1'b0;
      end
    end
    if (brk1 || brk2)
    begin
      arr1_nxt = '0;
      arr2_nxt = '0;
      for (int i = 0; i < 4; i++)
      begin
        pre_nxt[i] = '0;
        act_nxt[i] = '0;
      end
    end
    // Dead-time counters measure ticks since each output's rising request.
    dc0_nxt = (!raw_r[0]) ? 7'h00 : (tick && dc0_r < dt_act_r[6:0]) ? dc0_r + 7'h01 : dc0_r;
    dc1_nxt = raw_r[0] ? 7'h00 : (tick && dc1_r < dt_act_r[6:0]) ? dc1_r + 7'h01 : dc1_r;
    for (int i = 0; i < 4; i++)
    begin
      pre_out = raw_r[i];
      if (dt_on && i == 0)
      begin
        pre_out = raw_r[0] && dc0_r == dt_act_r[6:0];
      end
      else if (dt_on && i == 1)
      begin
        pre_out = !raw_r[0] && dc1_r == dt_act_r[6:0];
      end
      pre_out = pre_out ^ pol_act_r[i];
      if (dt_hold)
      begin
        pre_out = 1'b0;
      end
      if (i < 2 ? brk1 : brk2)
      begin
        pre_out = brk_r[`DAP_BRK_PAT + i];
      end
      out_nxt[i] = octl_r[i] && pre_out;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_r    <= `DAP_CTRL_RST;
      arr1_r    <= '0;
      arr2_r    <= '0;
      pre_r     <= '{default: '0};
      act_r     <= '{default: '0};
      octl_r    <= 8'h00;
      dtr_r     <= 8'h00;
      dt_act_r  <= 8'h00;
      brk_r     <= 10'h000;
      pol_act_r <= 4'h0;
      raw_r     <= 4'h0;
      out_r     <= 4'h0;
      dc0_r     <= 7'h00;
      dc1_r     <= 7'h00;
      sync_r    <= 2'b00;
    end
    else
    begin
      ctrl_r    <= ctrl_nxt;
      arr1_r    <= arr1_nxt;
      arr2_r    <= arr2_nxt;
      pre_r     <= pre_nxt;
      act_r     <= act_nxt;
      octl_r    <= octl_nxt;
      dtr_r     <= dtr_nxt;
      dt_act_r  <= dt_act_nxt;
      brk_r     <= brk_nxt;
      pol_act_r <= pol_act_nxt;
      raw_r     <= raw_nxt;
      out_r     <= out_nxt;
      dc0_r     <= dc0_nxt;
      dc1_r     <= dc1_nxt;
      sync_r    <= {sync_r[0], i_break_pin};
    end
  end

  assign o_pwm = out_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_pin_active;
    (i_break_pin == brk_r[`DAP_BRK_LVL] && brk_r[`DAP_BRK_BREAK_FUNCTION_ENABLE] && brk_r[`DAP_BRK_BREAK_SOURCE_SELECT])[*3];
  endsequence

  property p_reload;
    ovf1 && !brk1 |=> cnt1 == $past(arr1_r);
  endproperty
  a_reload: assert property (p_reload) else $error("Counter one missed reload.");

  property p_xfer;
    ovf1 && ctrl_r[`DAP_CTRL_TE1] && !brk1 && !brk2 |=> act_r[0] == $past(pre_r[0]);
  endproperty
  a_xfer: assert property (p_xfer) else $error("Preload not transferred.");

  property p_xfer_gate;
    !ovf1 && !brk1 && !brk2 |=> act_r[0] == $past(act_r[0]);
  endproperty
  a_xfer_gate: assert property (p_xfer_gate) else $error("Compare moved off overflow.");

  property p_high_on_ovf;
    ovf1 |=> raw_r[0];
  endproperty
  a_high_on_ovf: assert property (p_high_on_ovf) else $error("Output not set at overflow.");

  property p_low_on_match;
    !ovf1 && tick && cnt1 + 12'h001 == act_r[0] |=> !raw_r[0];
  endproperty
  a_low_on_match: assert property (p_low_on_match) else $error("Output not cleared at match.");

  property p_oe_off;
    !octl_r[0] |=> !o_pwm[0];
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("Disabled output driven high.");

  property p_break_pat;
    brk1 && octl_r[0] |=> o_pwm[0] == $past(brk_r[`DAP_BRK_PAT]);
  endproperty
  a_break_pat: assert property (p_break_pat) else $error("Break pattern not applied.");

  property p_break_clear;
    brk1 |=> cnt1 == 12'h000 && arr1_r == 12'h000;
  endproperty
  a_break_clear: assert property (p_break_clear) else $error("Break did not clear timer.");

  property p_dt_zero;
    dt_hold && !brk1 && !brk2 |=> o_pwm == 4'h0;
  endproperty
  a_dt_zero: assert property (p_dt_zero) else $error("Zero dead time not held low.");

  property p_pin_break;
    s_pin_active |=> brk_r[`DAP_BRK_BA];
  endproperty
  a_pin_break: assert property (p_pin_break) else $error("Pin level did not set break.");
endmodule

// File: verif/dap_bridge_model.sv
// Half-bridge power stage model that counts shoot-through cycles on outputs zero and one.
`timescale 1ns/1ps
module dap_bridge_model
(
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_arm,
  input  wire logic [3:0] i_pwm,
  output logic [15:0]     o_overlaps
);
  // Both switches of one leg conducting at once shorts the supply, so every such cycle counts while i_arm is high.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_overlaps <= 16'h0000;
    else if (i_arm && i_pwm[0] && i_pwm[1])
      o_overlaps <= o_overlaps + 16'h0001;
  end
endmodule

// File: verif/dap_top_bench.sv
// Self-checking testbench of the dual autoreload PWM unit.
`timescale 1ns/1ps
`include "dap_defines.svh"
module dap_top_bench;
  import dap_pkg::*;
  logic         clk;
  logic         rst_n;
  dap_axi_req_t axi_req;
  dap_axi_rsp_t axi_rsp;
  logic         ms_tick;
  logic         brk_pin;
  logic [3:0]   pwm;
  logic         dt_arm;
  logic [15:0]  overlaps;
  logic [31:0]  rdat;
  logic [1:0]   resp;
  logic [31:0]  hi [4];
  int           n_errors;
  int           n_compared;

  dap_top i_dap_top (.i_clk(clk), .i_rst_n(rst_n), .i_axi(axi_req), .o_axi(axi_rsp),
                     .i_ms_tick(ms_tick), .i_break_pin(brk_pin), .o_pwm(pwm));
  dap_bridge_model i_dap_bridge_model (.i_clk(clk), .i_rst_n(rst_n), .i_arm(dt_arm),
                                       .i_pwm(pwm), .o_overlaps(overlaps));

  always #10 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
  begin
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hf;
    axi_req.bready  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge clk);
      if (axi_req.awvalid && axi_rsp.awready)
      begin
        aw_done = 1'b1;
        axi_req.awvalid <= 1'b0;
      end
      if (axi_req.wvalid && axi_rsp.wready)
      begin
        w_done = 1'b1;
        axi_req.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (axi_rsp.bvalid !== 1'b1);
    resp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  end
  endtask

  task automatic rd(input logic [7:0] a);
  begin
    @(posedge clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do @(posedge clk); while (axi_rsp.arready !== 1'b1);
    axi_req.arvalid <= 1'b0;
    do @(posedge clk); while (axi_rsp.rvalid !== 1'b1);
    rdat = axi_rsp.rdata;
    resp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  end
  endtask

  // Counts high cycles per output over 64 cycles, a whole number of every period used here.
  task automatic measure(input int settle);
  begin
    repeat (settle) @(posedge clk);
    for (int c = 0; c < 4; c++)
      hi[c] = 32'h0;
    repeat (64)
    begin
      @(posedge clk);
      for (int c = 0; c < 4; c++)
        if (pwm[c] === 1'b1)
          hi[c]++;
    end
  end
  endtask

  task automatic finish_test;
  begin
    $display("Comparisons %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test;
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    axi_req = '0;
    ms_tick = 1'b0;
    brk_pin = 1'b0;
    dt_arm = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state, unmapped accesses.
    rd(`DAP_OFF_STAT);
    chk({31'h0, rdat[11:0] < 12'h010}, 32'h1);
    chk({20'h0, rdat[27:16]}, 32'h0);
    rd(`DAP_OFF_CTRL);
    chk(rdat, 32'h6);
    rd(8'h30);
    chk({rdat[29:0], resp}, {30'h0, `DAP_RESP_SLVERR});
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, `DAP_RESP_SLVERR});
    // Single mode: counter one period 16, duties 4, 8 and 12 cycles.
    wr(`DAP_OFF_ARR1, 32'hff0);
    wr(`DAP_OFF_DUTY0, 32'hff4);
    wr(`DAP_OFF_DUTY1, 32'hff8);
    wr(`DAP_OFF_DUTY2, 32'hffc);
    wr(`DAP_OFF_OCTL, 32'h0f);
    wr(`DAP_OFF_CTRL, 32'h0e);
    measure(32);
    chk(hi[0], 32'd16);
    chk(hi[1], 32'd32);
    chk(hi[2], 32'd48);
    // Polarity on a live output, enable removed from output zero.
    wr(`DAP_OFF_OCTL, 32'h4f);
    measure(32);
    chk(hi[2], 32'd16);
    wr(`DAP_OFF_OCTL, 32'h1e);
    measure(32);
    chk(hi[0], 32'd0);
    chk(hi[1], 32'd32);
    wr(`DAP_OFF_OCTL, 32'h1f);
    measure(32);
    chk(hi[0], 32'd48);
    // Preload held back while transfer enable one is clear.
    wr(`DAP_OFF_OCTL, 32'h0f);
    repeat (20) @(posedge clk);
    wr(`DAP_OFF_CTRL, 32'h04);
    wr(`DAP_OFF_DUTY0, 32'hff8);
    measure(32);
    chk(hi[0], 32'd16);
    wr(`DAP_OFF_CTRL, 32'h06);
    measure(32);
    chk(hi[0], 32'd32);
    // Dual mode: counter two period 8.
    wr(`DAP_OFF_ARR2, 32'hff8);
    wr(`DAP_OFF_DUTY3, 32'hffa);
    wr(`DAP_OFF_CTRL, 32'h07);
    wr(`DAP_OFF_CTRL, 32'h1f);
    measure(32);
    chk(hi[2], 32'd32);
    chk(hi[3], 32'd16);
    chk(hi[0], 32'd32);
    // Dead time of 2 ticks on the first pair, polarity left clear.
    wr(`DAP_OFF_OCTL, 32'h03);
    wr(`DAP_OFF_DTR, 32'h82);
    repeat (32) @(posedge clk);
    dt_arm <= 1'b1;
    measure(0);
    chk(hi[0], 32'd24);
    chk(hi[1], 32'd24);
    dt_arm <= 1'b0;
    chk({16'h0, overlaps}, 32'h0);
    // Counting on the millisecond tick switches dead time off.
    ms_tick <= 1'b1;
    wr(`DAP_OFF_CTRL, 32'h27);
    measure(32);
    chk(hi[0], 32'd32);
    chk(hi[1], 32'd32);
    wr(`DAP_OFF_CTRL, 32'h07);
    ms_tick <= 1'b0;
    wr(`DAP_OFF_DTR, 32'h80);
    measure(32);
    chk(hi[0] + hi[1], 32'd0);
    wr(`DAP_OFF_DTR, 32'h00);
    // Break from the pin, active high, pattern 0xa, both counters.
    wr(`DAP_OFF_OCTL, 32'h0f);
    wr(`DAP_OFF_BRK, 32'h3a7);
    brk_pin <= 1'b1;
    repeat (6) @(posedge clk);
    chk({28'h0, pwm}, 32'ha);
    rd(`DAP_OFF_BRK);
    chk({31'h0, rdat[3]}, 32'h1);
    rd(`DAP_OFF_STAT);
    chk(rdat, 32'h0);
    rd(`DAP_OFF_ARR1);
    chk(rdat, 32'h0);
    rd(`DAP_OFF_DUTY0);
    chk(rdat, 32'h0);
    brk_pin <= 1'b0;
    repeat (6) @(posedge clk);
    wr(`DAP_OFF_BRK, 32'h3a7);
    repeat (8) @(posedge clk);
    rd(`DAP_OFF_STAT);
    chk({31'h0, rdat[11:0] != 12'h000}, 32'h1);
    // Software break with output three disabled and all polarities inverted.
    wr(`DAP_OFF_OCTL, 32'hf7);
    wr(`DAP_OFF_BRK, 32'h3af);
    repeat (4) @(posedge clk);
    chk({28'h0, pwm}, 32'h2);
    finish_test;
  end
endmodule
